// >>> mdu_pkg.sv
// package of register addresses, fields and timing for the muldiv unit
package mdu_pkg;
  localparam logic [7:0] MDU_ADDR_BYTE0 = 8'hE9;
  localparam logic [7:0] MDU_ADDR_BYTE1 = 8'hEA;
  localparam logic [7:0] MDU_ADDR_BYTE2 = 8'hEB;
  localparam logic [7:0] MDU_ADDR_BYTE3 = 8'hEC;
  localparam logic [7:0] MDU_ADDR_BYTE4 = 8'hED;
  localparam logic [7:0] MDU_ADDR_BYTE5 = 8'hEE;
  localparam logic [7:0] MDU_ADDR_CTRL  = 8'hEF;
  localparam logic [7:0] MDU_CTRL_RESET = 8'h00;
  localparam int MDU_BIT_ERR  = 7;
  localparam int MDU_BIT_OVF  = 6;
  localparam int MDU_BIT_DIR  = 5;
  localparam int MDU_SC_MSB   = 4;
  // total busy cycles per operation, launch write excluded
  localparam logic [4:0] MDU_CYC_DIV32 = 5'd17;
  localparam logic [4:0] MDU_CYC_DIV16 = 5'd9;
  localparam logic [4:0] MDU_CYC_MUL   = 5'd11;
  localparam logic [4:0] MDU_CYC_SHIFT_BASE = 5'd2;
  localparam logic [4:0] MDU_CYC_NORM_BASE  = 5'd3;

  typedef enum logic [4:0] {
    MDU_OP_NONE  = 5'b00001,
    MDU_OP_DIV32 = 5'b00010,
    MDU_OP_DIV16 = 5'b00100,
    MDU_OP_MUL   = 5'b01000,
    MDU_OP_SHIFT = 5'b10000
  } mdu_op_t;

  typedef enum logic [2:0] {
    MDU_ST_IDLE = 3'b001,
    MDU_ST_LOAD = 3'b010,
    MDU_ST_RUN  = 3'b100
  } mdu_state_t;
endpackage

// >>> mdu_core.sv
// combinational unsigned arithmetic for the muldiv unit
`timescale 1ns/1ps
module mdu_core
  import mdu_pkg::*;
(
  input  wire logic [31:0] opnd_a,
  input  wire logic [15:0] opnd_b,
  input  wire mdu_op_t     op,
  input  wire logic        dir_right,
  input  wire logic [4:0]  shift_count,
  output logic      [47:0] result,
  output logic             overflow,
  output logic      [4:0]  norm_count
);
  // unsigned normalize: count leading zeros, stop at 31
  function automatic logic [4:0] lead_zeros(input logic [31:0] v);
    logic [4:0] n;
    logic       hit;
    n   = 5'd0;
    hit = 1'b0;
    // count zeros from the top until the first one, zero gives 31
    for (int i = 31; i >= 1; i--) begin
      if (!hit && !v[i]) begin
        n = n + 5'd1;
      end else begin
        hit = 1'b1;
      end
    end
    return n;
  endfunction

  logic [31:0] quot32;
  logic [15:0] rem16;
  logic [15:0] quot16;

  // result packing: bytes 0..3 main result, bytes 4..5 remainder
  always_comb begin
    result     = '0;
    overflow   = 1'b0;
    norm_count = 5'd0;
    quot32     = '0;
    rem16      = '0;
    quot16     = '0;
    case (op)
      MDU_OP_DIV32: begin
        if (opnd_b == 16'h0000) begin
          overflow = 1'b1;
        end else begin
          quot32 = opnd_a / {16'h0000, opnd_b};
          rem16  = 16'(opnd_a % {16'h0000, opnd_b});
        end
        result = {rem16, quot32};
      end
      MDU_OP_DIV16: begin
        if (opnd_b == 16'h0000) begin
          overflow = 1'b1;
        end else begin
          quot16 = opnd_a[15:0] / opnd_b;
          rem16  = opnd_a[15:0] % opnd_b;
        end
        result = {rem16, 16'h0000, quot16};
      end
      MDU_OP_MUL: begin
        // widen first so the full 32-bit product survives
        result = {16'h0000, 32'(opnd_a[15:0]) * 32'(opnd_b)};
      end
      MDU_OP_SHIFT: begin
        if (shift_count == 5'd0) begin
          norm_count = lead_zeros(opnd_a);
          result = {16'h0000, opnd_a << norm_count};
        end else if (dir_right) begin
          result = {16'h0000, opnd_a >> shift_count};
        end else begin
          result = {16'h0000, opnd_a << shift_count};
        end
      end
      default: begin
        result = '0;
      end
    endcase
  end
endmodule

// >>> mdu_top.sv
// muldiv unit: register file, sequence decode and timed execution
// Function
// - all operands and results are unsigned integers
// - byte registers sit at addresses 0xE9 through 0xEE
// - seven registers: six operand bytes and one control/status
// - unit computes on its own while the core keeps running
// - operands come from the byte registers, results return there
// - results overwrite the operands
// - control/status register configures and reports state
// - error flag bit 7 set when an operation is restarted
// - overflow flag bit 6 set on divide by zero
// - direction bit 5: zero shifts left, one shifts right
// - zero shift count normalizes and stores the shift count
// - nonzero shift count selects a plain shift
// - shift steps equal written count, bit 4 most significant
// - operation chosen by the order of byte register writes
// - byte zero write begins; byte five or control write launches
// - bytes two/three pick 32/16 divide, four 16/16, one multiply
// - divide 32/16 in 17, 16/16 in 9, multiply in 11 cycles
// - last result read ends the calculation
`timescale 1ns/1ps
module mdu_top
  import mdu_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  output logic            sfr_sel,
  output logic            busy
);
  // byte registers, control fields and sequencer
  logic [7:0]  md_q [6];
  logic [7:0]  md_d [6];
  logic        err_q, err_d;
  logic        ovf_q, ovf_d;
  logic        dir_q, dir_d;
  logic [4:0]  sc_q, sc_d;
  mdu_state_t  st_q, st_d;
  mdu_op_t     op_q, op_d;
  logic [5:0]  cnt_q, cnt_d;
  logic        pend_q, pend_d;
  logic [7:0]  rdata_q, rdata_d;

  logic        hit_md, hit_ctrl, launch;
  logic [2:0]  idx;
  logic [47:0] res;
  logic        res_ovf;
  logic [4:0]  res_norm;
  mdu_op_t     op_sel;

  // address decode of the seven registers
  always_comb begin
    hit_md   = (sfr_addr >= MDU_ADDR_BYTE0) && (sfr_addr <= MDU_ADDR_BYTE5);
    hit_ctrl = (sfr_addr == MDU_ADDR_CTRL);
    idx      = 3'(sfr_addr - MDU_ADDR_BYTE0);
  end

  assign sfr_sel = hit_md || hit_ctrl;
  assign busy    = (st_q == MDU_ST_RUN);

  // operation implied by the write sequence so far
  always_comb begin
    op_sel = op_q;
    if (st_q == MDU_ST_LOAD && sfr_wr && hit_ctrl) begin
      op_sel = MDU_OP_SHIFT;
    end
  end

  mdu_core u_core (
    .opnd_a      ({md_q[3], md_q[2], md_q[1], md_q[0]}),
    .opnd_b      (op_q == MDU_OP_MUL ? {md_q[5], md_q[4]}
                                      : {md_q[5], md_q[4]}),
    .op          (op_q),
    .dir_right   (dir_q),
    .shift_count (sc_q),
    .result      (res),
    .overflow    (res_ovf),
    .norm_count  (res_norm)
  );

  // next state of sequencer, registers and flags
  always_comb begin
    md_d    = md_q;
    err_d   = err_q;
    ovf_d   = ovf_q;
    dir_d   = dir_q;
    sc_d    = sc_q;
    st_d    = st_q;
    op_d    = op_q;
    cnt_d   = cnt_q;
    pend_d  = pend_q;
    rdata_d = rdata_q;
    launch  = 1'b0;

    // register reads; reading the final result byte clears the pending flag
    if (sfr_rd) begin
      if (hit_md) begin
        rdata_d = md_q[idx];
        if (pend_q && ((op_q == MDU_OP_DIV32 || op_q == MDU_OP_DIV16)
            ? idx == 3'd5 : idx == 3'd3)) begin
          pend_d = 1'b0;
        end
      end else if (hit_ctrl) begin
        rdata_d = {err_q, ovf_q, dir_q, sc_q};
      end else begin
        rdata_d = 8'h00;
      end
    end

    // sequence tracking on writes
    if (sfr_wr && sfr_sel) begin
      if (hit_md) begin
        md_d[idx] = sfr_wdata;
      end
      if (hit_ctrl) begin
        dir_d = sfr_wdata[MDU_BIT_DIR];
        sc_d  = sfr_wdata[MDU_SC_MSB:0];
      end
      // a new start while running restarts the unit
      if (st_q == MDU_ST_RUN && hit_md && idx == 3'd0) begin
        err_d = 1'b1;
      end
      if (hit_md && idx == 3'd0) begin
        st_d = MDU_ST_LOAD;
        op_d = MDU_OP_NONE;
        ovf_d = 1'b0;
        err_d = (st_q == MDU_ST_RUN);
      end else if (st_q == MDU_ST_LOAD) begin
        if (hit_md && (idx == 3'd2 || idx == 3'd3)) begin
          op_d = MDU_OP_DIV32;
        end else if (hit_md && idx == 3'd4 && op_q != MDU_OP_DIV32) begin
          op_d = MDU_OP_DIV16;
        end else if (hit_md && idx == 3'd1 && op_q != MDU_OP_DIV32) begin
          op_d = MDU_OP_MUL;
        end
        // launch on byte five (divide/multiply) or on control (shift)
        if ((hit_md && idx == 3'd5 && op_d != MDU_OP_NONE) || hit_ctrl) begin
          launch = 1'b1;
          op_d   = hit_ctrl ? op_sel : op_d;
          st_d   = MDU_ST_RUN;
          case (op_d)
            MDU_OP_DIV32: cnt_d = 6'(MDU_CYC_DIV32);
            MDU_OP_DIV16: cnt_d = 6'(MDU_CYC_DIV16);
            MDU_OP_MUL:   cnt_d = 6'(MDU_CYC_MUL);
            // six bits: base plus a count of 31 overflows five
            MDU_OP_SHIFT: cnt_d = (sfr_wdata[MDU_SC_MSB:0] == 5'd0)
                                  ? 6'(MDU_CYC_NORM_BASE)
                                  : 6'(MDU_CYC_SHIFT_BASE)
                                    + {1'b0, sfr_wdata[MDU_SC_MSB:0]};
            default:      cnt_d = 6'd1;
          endcase
        end
      end
    end

    // running: count down independent of core activity other than a byte zero write
    if (st_q == MDU_ST_RUN && !launch && !(sfr_wr && hit_md && idx == 3'd0))
    begin
      if (cnt_q == 6'd1) begin
        st_d = MDU_ST_IDLE;
        pend_d = 1'b1;
        for (int i = 0; i < 6; i++) begin
          md_d[i] = res[8*i +: 8];
        end
        if (op_q == MDU_OP_MUL) begin
          md_d[4] = md_q[4];
          md_d[5] = md_q[5];
        end
        if (op_q == MDU_OP_SHIFT) begin
          md_d[4] = md_q[4];
          md_d[5] = md_q[5];
          if (sc_q == 5'd0) begin
            sc_d = res_norm;
          end
        end
        if (res_ovf) begin
          ovf_d = 1'b1;
        end
      end else begin
        cnt_d = 6'(cnt_q - 6'd1);
      end
    end
  end

  // register stage
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 6; i++) begin
        md_q[i] <= 8'h00;
      end
      err_q   <= MDU_CTRL_RESET[MDU_BIT_ERR];
      ovf_q   <= MDU_CTRL_RESET[MDU_BIT_OVF];
      dir_q   <= MDU_CTRL_RESET[MDU_BIT_DIR];
      sc_q    <= MDU_CTRL_RESET[MDU_SC_MSB:0];
      st_q    <= MDU_ST_IDLE;
      op_q    <= MDU_OP_NONE;
      cnt_q   <= 6'd0;
      pend_q  <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      md_q    <= md_d;
      err_q   <= err_d;
      ovf_q   <= ovf_d;
      dir_q   <= dir_d;
      sc_q    <= sc_d;
      st_q    <= st_d;
      op_q    <= op_d;
      cnt_q   <= cnt_d;
      pend_q  <= pend_d;
      rdata_q <= rdata_d;
    end
  end

  assign sfr_rdata = rdata_q;
endmodule

// >>> mdu_top_props.sv
// assertions on the muldiv unit register port
`timescale 1ns/1ps
module mdu_props
  import mdu_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_sel,
  input wire logic       busy
);
  localparam int MAX_BUSY = 34;
  logic [7:0] run_q;
  logic [7:0] run_d;
  logic       launch;
  logic       b0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // launch and restart strobes
  assign launch = sfr_wr && sfr_addr inside {MDU_ADDR_BYTE5, MDU_ADDR_CTRL};
  assign b0     = sfr_wr && sfr_addr == MDU_ADDR_BYTE0;
  // length of the current busy run
  always_comb run_d = busy ? run_q + 8'h01 : 8'h00;
  always_ff @(posedge clk) run_q <= rst ? 8'h00 : run_d;
  sequence s_abort;
    busy ##0 b0;
  endsequence
  property p_sel;
    sfr_sel == (sfr_addr inside {[MDU_ADDR_BYTE0:MDU_ADDR_CTRL]});
  endproperty
  property p_unmap;
    sfr_rd && !sfr_sel |=> sfr_rdata == 8'h00;
  endproperty
  property p_hold;
    !sfr_rd |=> $stable(sfr_rdata);
  endproperty
  property p_idle;
    !busy && !launch |=> !busy;
  endproperty
  property p_abort;
    s_abort |=> !busy;
  endproperty
  property p_min;
    $rose(busy) && !b0 |=> busy;
  endproperty
  property p_reset;
    $fell(rst) |-> sfr_rdata == 8'h00 && !busy;
  endproperty
  a_sel: assert property (p_sel) else $error("select decode wrong");
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_idle: assert property (p_idle) else $error("start no launch");
  a_abort: assert property (p_abort) else $error("restart kept run");
  a_min: assert property (p_min) else $error("run too short");
  a_reset: assert property (p_reset) else $error("reset state");
  a_max: assert property (run_q <= MAX_BUSY) else $error("run long");
endmodule
bind mdu_top mdu_props mdu_props_i (.clk(clk), .rst(rst), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata), .sfr_sel(sfr_sel), .busy(busy));

// >>> mdu_cpu_model.sv
// core-side register access model for the muldiv unit
`timescale 1ns/1ps
module mdu_cpu_model (
  input  wire logic       clk,
  output logic      [7:0] sfr_addr,
  output logic            sfr_wr,
  output logic      [7:0] sfr_wdata,
  output logic            sfr_rd,
  input  wire logic [7:0] sfr_rdata
);
  // idle bus at time zero
  initial begin
    sfr_addr  = 8'h00;
    sfr_wr    = 1'b0;
    sfr_wdata = 8'h00;
    sfr_rd    = 1'b0;
  end
  // one access at a time, never nested
  task automatic xs(input logic [7:0] a, input logic w,
                    input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = w;
    sfr_rd    = ~w;
    @(negedge clk);
    q         = sfr_rdata;
    sfr_wr    = 1'b0;
    sfr_rd    = 1'b0;
    sfr_addr  = 8'h00;
    sfr_wdata = ~d;
  endtask
endmodule

// >>> mdu_top_tb.sv
// self-checking testbench for the muldiv unit
`timescale 1ns/1ps
module mdu_top_tb
  import mdu_pkg::*;
;
  logic       clk;
  logic       rst;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic [7:0] sfr_wdata;
  logic       sfr_rd;
  logic [7:0] sfr_rdata;
  logic       sfr_sel;
  logic       busy;
  logic [7:0] rv;
  int         n_fail = 0;
  int         checks = 0;
  // unit and its core-side model
  mdu_top mdu_top_i (.clk(clk), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .sfr_sel(sfr_sel), .busy(busy));
  mdu_cpu_model mdu_cpu_model_i (.clk(clk), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata));
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic complete_run;
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    mdu_cpu_model_i.xs(a, 1'b0, 8'h00, rv);
    chk({24'h00_0000, rv}, {24'h00_0000, e});
  endtask
  task automatic rd32(input logic [31:0] e);
    for (int i = 0; i < 4; i++)
      rdc(MDU_ADDR_BYTE0 + 8'(i), e[8*i+:8]);
  endtask
  // write n bytes lsb first, then time the busy run
  task automatic run(input logic [47:0] a, input logic [47:0] d,
                     input int n, input int cyc);
    int k;
    for (int i = 0; i < n; i++)
      mdu_cpu_model_i.xs(a[8*i+:8], 1'b1, d[8*i+:8], rv);
    if (cyc < 0) return;
    k = 0;
    while (busy === 1'b1 && k < 64) begin
      @(negedge clk);
      k++;
    end
    chk(32'(k), 32'(cyc));
  endtask
  task automatic t_reset;
    for (int i = 0; i < 7; i++)
      rdc(MDU_ADDR_BYTE0 + 8'(i), 8'h00);
  endtask
  task automatic t_unmapped;
    mdu_cpu_model_i.xs(8'hF0, 1'b1, 8'h5A, rv);
    rdc(8'hF0, 8'h00);
    rdc(8'hE8, 8'h00);
  endtask
  task automatic t_mul;
    logic [15:0] a;
    logic [15:0] b;
    a = 16'h1234;
    b = 16'hABCD;
    run(48'h0000_EEEA_EDE9, {16'h0000, b[15:8], a[15:8], b[7:0], a[7:0]},
        4, MDU_CYC_MUL);
    rd32({16'h0000, a} * {16'h0000, b});
  endtask
  task automatic t_div32;
    logic [31:0] n;
    logic [15:0] m;
    n = 32'hDEAD_BEEF;
    m = 16'h0107;
    run(48'hEEED_ECEB_EAE9, {m, n}, 6, MDU_CYC_DIV32);
    rd32(n / m);
    rdc(MDU_ADDR_BYTE4, 8'(n % m));
    rdc(MDU_ADDR_BYTE5, 8'((n % m) >> 8));
  endtask
  task automatic t_div16(input logic [15:0] m);
    logic [15:0] n;
    logic [31:0] e;
    n = 16'hABCD;
    run(48'h0000_EEED_EAE9, {16'h0000, m, n}, 4, MDU_CYC_DIV16);
    mdu_cpu_model_i.xs(MDU_ADDR_CTRL, 1'b0, 8'h00, rv);
    chk(32'(rv[MDU_BIT_OVF]), 32'(m == 16'h0000));
    if (m == 16'h0000) return;
    e = {16'(n % m), 16'(n / m)};
    for (int i = 0; i < 4; i++)
      rdc((i < 2 ? MDU_ADDR_BYTE0 : MDU_ADDR_BYTE2) + 8'(i), e[8*i+:8]);
  endtask
  task automatic sh(input logic [31:0] v, input logic [7:0] c,
                    input logic [31:0] e, input int cyc);
    run(48'h00EF_ECEB_EAE9, {8'h00, c, v}, 5, cyc);
    rd32(e);
  endtask
  task automatic t_shift;
    sh(32'h8765_4321, 8'h04, 32'h7654_3210,
       int'(MDU_CYC_SHIFT_BASE) + 4);
    sh(32'h8765_4321, 8'h3F, 32'h0000_0001,
       int'(MDU_CYC_SHIFT_BASE) + 31);
  endtask
  task automatic t_norm;
    sh(32'h0001_2345, 8'h00, 32'h0001_2345 << 15,
       int'(MDU_CYC_NORM_BASE));
    rdc(MDU_ADDR_CTRL, 8'h0F);
  endtask
  task automatic t_abort;
    run(48'h0000_0000_EEE9, 48'h0, 2, 0);
    run(48'h0000_EEEA_EDE9, 48'h0000_0102_0304, 4, -1);
    repeat (3) @(negedge clk);
    run(48'h0000_0000_00E9, 48'h0, 1, 0);
    mdu_cpu_model_i.xs(MDU_ADDR_CTRL, 1'b0, 8'h00, rv);
    chk(32'(rv[MDU_BIT_ERR]), 32'h0000_0001);
  endtask
  // main sequence
  initial begin
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_reset;
    t_unmapped;
    t_mul;
    t_div32;
    t_div16(16'h0012);
    t_div16(16'h0000);
    t_shift;
    t_norm;
    t_abort;
    complete_run;
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run;
  end
endmodule
